// *** hw/ascr_map.svh ***
// register offsets, field positions, reset values and timing figures of the sample configuration bank
`ifndef ASCR_MAP_SVH
`define ASCR_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define ASCR_IDX_ST_X      8'h0D
`define ASCR_IDX_ST_Y      8'h0E
`define ASCR_IDX_ST_Z      8'h0F
`define ASCR_IDX_RATE_DIV  8'h19
`define ASCR_IDX_CONFIG    8'h1A
`define ASCR_IDX_ACCEL_CFG 8'h1C
`define ASCR_IDX_BYPASS    8'h30
`define ASCR_IDX_STATUS    8'h31

// ************************************************************
// reset values
// ************************************************************
`define ASCR_RST_BYTE      8'h00
`define ASCR_RST_ST_REF    8'h00

// ************************************************************
// field positions
// ************************************************************
`define ASCR_CFG_FIFO_MODE 6
`define ASCR_CFG_SYNC_HI   5
`define ASCR_CFG_SYNC_LO   3
`define ASCR_CFG_LP_HI     2
`define ASCR_CFG_LP_LO     0
`define ASCR_ACF_X_ST      7
`define ASCR_ACF_Y_ST      6
`define ASCR_ACF_Z_ST      5
`define ASCR_ACF_RANGE_HI  4
`define ASCR_ACF_RANGE_LO  3
`define ASCR_BYP_PATH_HI   1
`define ASCR_BYP_PATH_LO   0
`define ASCR_BYP_ACCEL     2

// ************************************************************
// lowpass codes and temperature bandwidths in Hz
// ************************************************************
`define ASCR_LP_OFF_LO     3'h0
`define ASCR_LP_OFF_HI     3'h7
`define ASCR_BW_WIDE       13'd4000
`define ASCR_BW_SET1       13'd188
`define ASCR_BW_SET2       13'd98
`define ASCR_BW_SET3       13'd42
`define ASCR_BW_SET4       13'd20
`define ASCR_BW_SET5       13'd10
`define ASCR_BW_SET6       13'd5

// ************************************************************
// timing
// ************************************************************
`define ASCR_MCLK_HZ       50000000
`define ASCR_INT_RATE_HZ   1000
`define ASCR_FAST_RATE_HZ  4000

`endif

// *** hw/ascr_pkg.sv ***
// types shared by the sample configuration bank
package ascr_pkg;

   // full-scale range codes
   typedef enum logic [1:0] {
      ASCR_RANGE_2G  = 2'h0,
      ASCR_RANGE_4G  = 2'h1,
      ASCR_RANGE_8G  = 2'h2,
      ASCR_RANGE_16G = 2'h3
   } ascr_range_type;

   // where the frame sync bit is inserted
   typedef enum logic [2:0] {
      ASCR_SYNC_OFF  = 3'h0,
      ASCR_SYNC_TEMP = 3'h1,
      ASCR_SYNC_RSV2 = 3'h2,
      ASCR_SYNC_RSV3 = 3'h3,
      ASCR_SYNC_RSV4 = 3'h4,
      ASCR_SYNC_X    = 3'h5,
      ASCR_SYNC_Y    = 3'h6,
      ASCR_SYNC_Z    = 3'h7
   } ascr_sync_type;

   // one 16-bit sample per channel: 0 temp, 1 x, 2 y, 3 z
   typedef logic [3:0][15:0] ascr_samples_type;

endpackage

// *** hw/ascr_rate_gen.sv ***
// internal rate tick and divided sample strobe generator
`timescale 1ns/1ps
`include "ascr_map.svh"
module ascr_rate_gen #(
   parameter int unsigned SLOW_CYC = 50000,
   parameter int unsigned FAST_CYC = 12500
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // rate settings and strobes
   ascr_rate_if.gen rif
);
   import ascr_pkg::*;

   localparam logic [15:0] SLOW_LAST = 16'(SLOW_CYC - 1);
   localparam logic [15:0] FAST_LAST = 16'(FAST_CYC - 1);

   logic [15:0] base_cnt_reg;
   logic [7:0]  div_cnt_reg;
   logic        tick_reg;
   logic        strobe_reg;
   logic        base_wrap;

   // base period: 4 kHz when the accel filter is bypassed, else 1 kHz
   assign base_wrap = (base_cnt_reg >= (rif.fast_rate ? FAST_LAST : SLOW_LAST));

   // base period counter
   always_ff @(posedge mclk) begin
      if (sys_rst || base_wrap) begin
         base_cnt_reg <= 16'h0000;
      end else begin
         base_cnt_reg <= base_cnt_reg + 16'h0001;
      end
   end

   // internal rate tick
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= base_wrap;
      end
   end

   // divide by one plus the divider only while the divider is in force
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_cnt_reg <= 8'h00;
         strobe_reg  <= 1'b0;
      end else if (base_wrap) begin
         if (!rif.div_effective || div_cnt_reg >= rif.rate_div) begin
            div_cnt_reg <= 8'h00;
            strobe_reg  <= 1'b1;
         end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
            strobe_reg  <= 1'b0;
         end
      end else begin
         strobe_reg <= 1'b0;
      end
   end

   assign rif.internal_tick = tick_reg;
   assign rif.sample_strobe = strobe_reg;
endmodule

// *** hw/ascr_rate_if.sv ***
// rate settings and strobes passed between the register bank and the rate generator
`timescale 1ns/1ps
interface ascr_rate_if;
   logic [7:0] rate_div;
   logic       div_effective;
   logic       fast_rate;
   logic       internal_tick;
   logic       sample_strobe;

   modport ctrl (output rate_div, output div_effective, output fast_rate,
                 input internal_tick, input sample_strobe);
   modport gen  (input rate_div, input div_effective, input fast_rate,
                 output internal_tick, output sample_strobe);
endinterface

// *** hw/ascr_regs.sv ***
// sample rate, filter, sync, fifo policy and self-test configuration bank on apb
`timescale 1ns/1ps
`include "ascr_map.svh"
module ascr_regs #(
   parameter int unsigned SLOW_CYC  = `ASCR_MCLK_HZ / `ASCR_INT_RATE_HZ,
   parameter int unsigned FAST_CYC  = `ASCR_MCLK_HZ / `ASCR_FAST_RATE_HZ,
   parameter logic [7:0]  ST_X_INIT = `ASCR_RST_ST_REF,
   parameter logic [7:0]  ST_Y_INIT = `ASCR_RST_ST_REF,
   parameter logic [7:0]  ST_Z_INIT = `ASCR_RST_ST_REF
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [9:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // frame sync pin
   input  wire logic                     frame_sync_pin,
   // sample path
   input  wire ascr_pkg::ascr_samples_type sample_raw,
   output ascr_pkg::ascr_samples_type    sample_out,
   output logic                          sample_strobe,
   // fifo side
   input  wire logic                     fifo_full,
   output logic                          fifo_wr,
   output logic                          fifo_drop_oldest,
   // sensor controls
   output logic [2:0]                    selftest_stim,
   output ascr_pkg::ascr_range_type      range_select,
   output logic                          lowpass_enable,
   output logic [2:0]                    lowpass_setting,
   output logic                          accel_rate_4k,
   output logic [12:0]                   temp_bw_hz,
   output logic                          lownoise_mode
);
   import ascr_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [7:0]       st_ref_reg [3];
   logic [7:0]       rate_div_reg;
   logic             fifo_mode_reg;
   ascr_sync_type    sync_source_sel_reg;
   logic [2:0]       lp_setting_reg;
   logic [2:0]       st_en_reg;
   ascr_range_type   range_reg;
   logic [1:0]       filter_bypass_bits_reg;
   logic             accel_filter_bypass_reg;
   logic [31:0]      prdata_reg;
   logic [31:0]      rd_next;
   logic             pready_reg;
   logic             pslverr_reg;
   logic             hit_next;
   logic             fs_meta_reg;
   logic             fs_sync_reg;
   logic             fs_prev_reg;
   logic             fs_latch_reg;
   logic             fs_toggle;
   ascr_samples_type out_reg;
   logic             fifo_wr_reg;
   logic             fifo_drop_reg;
   logic             div_eff_reg;
   logic             lp_en_reg;
   logic [12:0]      temp_bw_reg;
   logic [12:0]      temp_bw_next;
   logic [2:0]       stim_reg;
   logic             lownoise_reg;
   logic [7:0]       word_idx;
   logic             acc_go;
   logic             wr_go;
   logic             strobe;
   logic             lp_mid;

   ascr_rate_if rif ();

   // ************************************************************
   // apb slave
   // ************************************************************
   assign word_idx = paddr[9:2];
   assign acc_go   = psel && penable && pready_reg;
   assign wr_go    = acc_go && pwrite && !pslverr_reg;

   // read mux and address decode
   always_comb begin
      rd_next  = 32'h0000_0000;
      hit_next = 1'b1;
      unique case (word_idx)
         `ASCR_IDX_ST_X:      rd_next[7:0] = st_ref_reg[0];
         `ASCR_IDX_ST_Y:      rd_next[7:0] = st_ref_reg[1];
         `ASCR_IDX_ST_Z:      rd_next[7:0] = st_ref_reg[2];
         `ASCR_IDX_RATE_DIV:  rd_next[7:0] = rate_div_reg;
         `ASCR_IDX_CONFIG:    rd_next[7:0] = {1'b0, fifo_mode_reg, sync_source_sel_reg, lp_setting_reg};
         `ASCR_IDX_ACCEL_CFG: rd_next[7:0] = {st_en_reg, range_reg, 3'h0};
         `ASCR_IDX_BYPASS:    rd_next[7:0] = {5'h00, accel_filter_bypass_reg, filter_bypass_bits_reg};
         `ASCR_IDX_STATUS:    rd_next[7:0] = {3'h0, lownoise_reg, fifo_full, accel_filter_bypass_reg,
                                             lp_en_reg, div_eff_reg};
         default:             hit_next = 1'b0;
      endcase
   end

   // one wait state, then answer with data and error flag
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (psel && penable && !pready_reg) begin
         pready_reg  <= 1'b1;
         prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
         pslverr_reg <= !hit_next || (pwrite && word_idx == `ASCR_IDX_STATUS);
      end else begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   // factory self-test references, one byte per axis
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ref_reg[0] <= ST_X_INIT;
         st_ref_reg[1] <= ST_Y_INIT;
         st_ref_reg[2] <= ST_Z_INIT;
      end else if (wr_go) begin
         if (word_idx == `ASCR_IDX_ST_X) st_ref_reg[0] <= pwdata[7:0];
         if (word_idx == `ASCR_IDX_ST_Y) st_ref_reg[1] <= pwdata[7:0];
         if (word_idx == `ASCR_IDX_ST_Z) st_ref_reg[2] <= pwdata[7:0];
      end
   end

   // sample rate divider
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rate_div_reg <= `ASCR_RST_BYTE;
      end else if (wr_go && word_idx == `ASCR_IDX_RATE_DIV) begin
         rate_div_reg <= pwdata[7:0];
      end
   end

   // fifo policy, sync source and lowpass setting; top bit always zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fifo_mode_reg       <= 1'b0;
         sync_source_sel_reg <= ASCR_SYNC_OFF;
         lp_setting_reg      <= 3'h0;
      end else if (wr_go && word_idx == `ASCR_IDX_CONFIG) begin
         fifo_mode_reg       <= pwdata[`ASCR_CFG_FIFO_MODE];
         sync_source_sel_reg <= ascr_sync_type'(pwdata[`ASCR_CFG_SYNC_HI:`ASCR_CFG_SYNC_LO]);
         lp_setting_reg      <= pwdata[`ASCR_CFG_LP_HI:`ASCR_CFG_LP_LO];
      end
   end

   // self-test enables and full-scale range
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_en_reg <= 3'h0;
         range_reg <= ASCR_RANGE_2G;
      end else if (wr_go && word_idx == `ASCR_IDX_ACCEL_CFG) begin
         st_en_reg <= {pwdata[`ASCR_ACF_X_ST], pwdata[`ASCR_ACF_Y_ST], pwdata[`ASCR_ACF_Z_ST]};
         range_reg <= ascr_range_type'(pwdata[`ASCR_ACF_RANGE_HI:`ASCR_ACF_RANGE_LO]);
      end
   end

   // filter bypass controls
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         filter_bypass_bits_reg  <= 2'h0;
         accel_filter_bypass_reg <= 1'b0;
      end else if (wr_go && word_idx == `ASCR_IDX_BYPASS) begin
         filter_bypass_bits_reg  <= pwdata[`ASCR_BYP_PATH_HI:`ASCR_BYP_PATH_LO];
         accel_filter_bypass_reg <= pwdata[`ASCR_BYP_ACCEL];
      end
   end

   // ************************************************************
   // filter and rate decisions
   // ************************************************************
   assign lp_mid = (lp_setting_reg != `ASCR_LP_OFF_LO) && (lp_setting_reg != `ASCR_LP_OFF_HI);

   // temperature bandwidth lookup
   always_comb begin
      temp_bw_next = `ASCR_BW_WIDE;
      if (filter_bypass_bits_reg == 2'h0) begin
         unique case (lp_setting_reg)
            3'h1:    temp_bw_next = `ASCR_BW_SET1;
            3'h2:    temp_bw_next = `ASCR_BW_SET2;
            3'h3:    temp_bw_next = `ASCR_BW_SET3;
            3'h4:    temp_bw_next = `ASCR_BW_SET4;
            3'h5:    temp_bw_next = `ASCR_BW_SET5;
            3'h6:    temp_bw_next = `ASCR_BW_SET6;
            default: temp_bw_next = `ASCR_BW_WIDE;
         endcase
      end
   end

   // registered filter, rate and bandwidth settings
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_eff_reg <= 1'b0;
         lp_en_reg   <= 1'b0;
         temp_bw_reg <= `ASCR_BW_WIDE;
      end else begin
         div_eff_reg <= (filter_bypass_bits_reg == 2'h0) && lp_mid;
         lp_en_reg   <= (filter_bypass_bits_reg == 2'h0);
         temp_bw_reg <= temp_bw_next;
      end
   end

   assign rif.rate_div      = rate_div_reg;
   assign rif.div_effective = div_eff_reg;
   assign rif.fast_rate     = accel_filter_bypass_reg;
   assign strobe            = rif.sample_strobe;

   ascr_rate_gen #(
      .SLOW_CYC (SLOW_CYC),
      .FAST_CYC (FAST_CYC)
   ) u_rate_gen (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .rif     (rif)
   );

   // ************************************************************
   // frame sync capture
   // ************************************************************
   // two-stage synchroniser, then edge history
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fs_meta_reg <= 1'b0;
         fs_sync_reg <= 1'b0;
         fs_prev_reg <= 1'b0;
      end else begin
         fs_meta_reg <= frame_sync_pin;
         fs_sync_reg <= fs_meta_reg;
         fs_prev_reg <= fs_sync_reg;
      end
   end

   assign fs_toggle = fs_sync_reg ^ fs_prev_reg;

   // toggle latch: cleared by the strobe, a toggle in that cycle wins
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fs_latch_reg <= 1'b0;
      end else if (fs_toggle) begin
         fs_latch_reg <= 1'b1;
      end else if (strobe) begin
         fs_latch_reg <= 1'b0;
      end
   end

   // per-channel output update with optional sync bit in bit 0
   for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      localparam ascr_sync_type CODE = (ch == 0) ? ASCR_SYNC_TEMP : ascr_sync_type'(3'(ch + 4));
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            out_reg[ch] <= 16'h0000;
         end else if (strobe) begin
            out_reg[ch][15:1] <= sample_raw[ch][15:1];
            out_reg[ch][0]    <= (sync_source_sel_reg == CODE) ? fs_latch_reg : sample_raw[ch][0];
         end
      end
   end

   // ************************************************************
   // fifo write policy
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fifo_wr_reg   <= 1'b0;
         fifo_drop_reg <= 1'b0;
      end else begin
         fifo_wr_reg   <= strobe && !(fifo_full && fifo_mode_reg);
         fifo_drop_reg <= strobe && fifo_full && !fifo_mode_reg;
      end
   end

   // ************************************************************
   // self-test stimulus and operating mode
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stim_reg     <= 3'h0;
         lownoise_reg <= 1'b1;
      end else begin
         stim_reg     <= st_en_reg;
         lownoise_reg <= 1'b1;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign sample_out       = out_reg;
   assign sample_strobe    = rif.sample_strobe;
   assign fifo_wr          = fifo_wr_reg;
   assign fifo_drop_oldest = fifo_drop_reg;
   assign selftest_stim    = stim_reg;
   assign range_select     = range_reg;
   assign lowpass_enable   = lp_en_reg;
   assign lowpass_setting  = lp_setting_reg;
   assign accel_rate_4k    = accel_filter_bypass_reg;
   assign temp_bw_hz       = temp_bw_reg;
   assign lownoise_mode    = lownoise_reg;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_write(logic [7:0] idx);
      psel && penable && pready && pwrite && !pslverr && word_idx == idx;
   endsequence

   sequence s_full_strobe;
      strobe && fifo_full;
   endsequence

   a_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered after one wait state");
   a_st_ref_store: assert property (s_write(`ASCR_IDX_ST_Y) |=> st_ref_reg[1] == $past(pwdata[7:0]))
      else $error("self-test reference write lost");
   a_div_gate: assert property (##1 div_eff_reg == ($past(filter_bypass_bits_reg) == 2'h0 &&
                                $past(lp_setting_reg) != 3'h0 && $past(lp_setting_reg) != 3'h7))
      else $error("divider gating wrong");
   a_fifo_keep: assert property (s_full_strobe and fifo_mode_reg |=> !fifo_wr && !fifo_drop_oldest)
      else $error("fifo written while full in keep mode");
   a_fifo_overwrite: assert property (s_full_strobe and !fifo_mode_reg |=> fifo_wr && fifo_drop_oldest)
      else $error("oldest fifo entry not replaced");
   a_sync_x_bit: assert property (strobe && sync_source_sel_reg == ASCR_SYNC_X |=>
                                  sample_out[1][0] == $past(fs_latch_reg))
      else $error("sync bit not in x low byte");
   a_sync_reserved: assert property (strobe && sync_source_sel_reg inside {[3'h2:3'h4]} |=>
                                     sample_out == $past(sample_raw))
      else $error("reserved sync code altered data");
   a_sync_latch: assert property (fs_toggle |=> fs_latch_reg)
      else $error("sync toggle not latched");
   a_temp_bw: assert property (filter_bypass_bits_reg != 2'h0 ##1 filter_bypass_bits_reg != 2'h0
                               |=> temp_bw_hz == `ASCR_BW_WIDE)
      else $error("bypassed temperature bandwidth wrong");
   a_lowpass_on: assert property (lowpass_enable |-> $past(filter_bypass_bits_reg) == 2'h0)
      else $error("lowpass on while bypassed");
   a_stim_axis: assert property (##1 selftest_stim == $past(st_en_reg))
      else $error("self-test stimulus not per axis");
   a_mode_lownoise: assert property (lownoise_mode)
      else $error("not in low-noise mode");
endmodule

// *** verification/tb_accel_sample_config_regs.sv ***
// self-checking bench for the sample configuration register bank
`timescale 1ns/1ps
module tb_accel_sample_config_regs;
   import ascr_pkg::*;
   logic             mclk = 1'b0;
   logic             sys_rst = 1'b1;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [9:0]       paddr = 10'h000;
   logic [31:0]      pwdata = 32'h0;
   logic [31:0]      prdata;
   logic             pready, pslverr, sample_strobe, fifo_wr, fifo_drop_oldest;
   logic             frame_sync_pin = 1'b0;
   logic             fifo_full = 1'b0;
   ascr_samples_type sample_raw = {4{16'hAAAA}};
   ascr_samples_type sample_out;
   logic [2:0]       selftest_stim, lowpass_setting;
   ascr_range_type   range_select;
   logic             lowpass_enable, accel_rate_4k, lownoise_mode;
   logic [12:0]      temp_bw_hz;
   int               n_fail = 0;
   int               total_checks = 0;
   int               n;
   // ************************************************************
   // clock, reset and design
   // ************************************************************
   initial begin
      forever #10 mclk = ~mclk;
   end
   ascr_regs #(.SLOW_CYC(40), .FAST_CYC(10)) dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_sync_pin(frame_sync_pin), .sample_raw(sample_raw), .sample_out(sample_out),
      .sample_strobe(sample_strobe), .fifo_full(fifo_full), .fifo_wr(fifo_wr),
      .fifo_drop_oldest(fifo_drop_oldest), .selftest_stim(selftest_stim), .range_select(range_select),
      .lowpass_enable(lowpass_enable), .lowpass_setting(lowpass_setting), .accel_rate_4k(accel_rate_4k),
      .temp_bw_hz(temp_bw_hz), .lownoise_mode(lownoise_mode));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [31:0] er,
                      input logic ee);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      if (!w) chk(prdata, er);
      chk(pslverr, ee);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic wstb();
      do @(posedge mclk); while (sample_strobe !== 1'b1);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs();
      chk(lownoise_mode, 1'b1);
      apb(1'b0, 8'h31, 0, 32'h12, 1'b0);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'h0D + i, 0, 0, 1'b0);
         apb(1'b1, 8'h0D + i, 32'hFFFFFF5A + i, 0, 1'b0);
         apb(1'b0, 8'h0D + i, 0, 32'h5A + i, 1'b0);
      end
      apb(1'b0, 8'h20, 0, 0, 1'b1);
      apb(1'b1, 8'h31, 32'hFF, 0, 1'b1);
      $display("test regs done");
   endtask
   task automatic t_filter();
      logic [12:0] bw [8] = '{13'hFA0, 13'h0BC, 13'h062, 13'h02A, 13'h014, 13'h00A, 13'h005, 13'hFA0};
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, 8'h1A, s, 0, 1'b0);
         chk(temp_bw_hz, bw[s]);
         chk(lowpass_enable, 1'b1);
         chk(lowpass_setting, s);
      end
      apb(1'b1, 8'h30, 32'h02, 0, 1'b0);
      chk(temp_bw_hz, 13'hFA0);
      chk(lowpass_enable, 1'b0);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, 8'h1C, (32'h20 << (r % 3)) | (r << 3), 0, 1'b0);
         apb(1'b0, 8'h1C, 0, (32'h20 << (r % 3)) | (r << 3), 1'b0);
         chk(range_select, r);
         chk(selftest_stim, 3'h1 << (r % 3));
      end
      apb(1'b1, 8'h1C, 32'h00, 0, 1'b0);
      chk(selftest_stim, 3'h0);
      $display("test filter done");
   endtask
   task automatic t_rate();
      logic [7:0] cfg [4] = '{8'h01, 8'h07, 8'h01, 8'h01};
      logic [7:0] byp [4] = '{8'h00, 8'h00, 8'h01, 8'h04};
      int         per [4] = '{120, 40, 40, 30};
      apb(1'b1, 8'h19, 32'h02, 0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h1A, cfg[i], 0, 1'b0);
         apb(1'b1, 8'h30, byp[i], 0, 1'b0);
         chk(accel_rate_4k, byp[i][2]);
         wstb();
         wstb();
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (sample_strobe !== 1'b1 && n < 500);
         chk(n, per[i]);
      end
      apb(1'b1, 8'h30, 32'h00, 0, 1'b0);
      $display("test rate done");
   endtask
   task automatic t_fifo();
      logic [7:0] cfg [3] = '{8'h47, 8'h07, 8'h47};
      logic       ful [3] = '{1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'h1A, cfg[i], 0, 1'b0);
         fifo_full <= ful[i];
         wstb();
         wstb();
         @(posedge mclk);
         chk(fifo_wr, !(ful[i] && cfg[i][6]));
         chk(fifo_drop_oldest, ful[i] && !cfg[i][6]);
      end
      fifo_full <= 1'b0;
      $display("test fifo done");
   endtask
   task automatic t_sync();
      logic [2:0] code [5] = '{3'h1, 3'h5, 3'h6, 3'h7, 3'h3};
      int         chan [5] = '{0, 1, 2, 3, 9};
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 8'h1A, {2'b00, code[i], 3'h7}, 0, 1'b0);
         wstb();
         frame_sync_pin <= ~frame_sync_pin;
         wstb();
         @(posedge mclk);
         for (int c = 0; c < 4; c++) chk(sample_out[c], 16'hAAAA | (c == chan[i]));
      end
      $display("test sync done");
   endtask
   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      t_regs();
      t_filter();
      t_rate();
      t_fifo();
      t_sync();
      final_report();
   end
   initial begin
      repeat (30000) @(posedge mclk);
      n_fail++;
      final_report();
   end
endmodule
